/* logic/atx_decoder.sv */
`timescale 1ns/1ps
module atx_decoder
   import atx_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Display control two
   output logic [3:0] display_ctrl_two,
   output logic display_ctrl_two_we,
   // Display tick timer and its reload
   output logic [3:0] display_tick_timer,
   output logic [3:0] display_tick_reload,
   output logic display_tick_we,
   // Clock control
   output logic [3:0] clock_control_register,
   output logic clock_control_we,
   // Timer control bit
   output logic [0:0] timer_ctrl_bit_register,
   output logic timer_ctrl_we,
   // Data memory store
   output logic mem_we,
   output logic [7:0] mem_addr,
   output logic [3:0] mem_wdata
);

   logic [9:0] opcode;
   logic exec_pend;
   logic [3:0] accumulator;
   logic carry_flag;
   logic [3:0] ptr_high;
   logic [3:0] ptr_low;
   logic setup_cyc;
   logic wr_take;
   logic hit;
   logic [31:0] rd_word;
   logic is_dct2;
   logic is_tick;
   logic is_clk;
   logic is_tmr;
   logic is_store;

   assign setup_cyc = psel && !penable;
   assign wr_take = psel && penable && pwrite && pready;

   assign is_dct2 = exec_pend && (opcode == OPC_DCT2);
   assign is_tick = exec_pend && (opcode == OPC_TICK);
   assign is_clk = exec_pend && (opcode == OPC_CLK);
   assign is_tmr = exec_pend && (opcode == OPC_TMR);
   assign is_store = exec_pend && ((opcode & OPC_STORE_MASK) == OPC_STORE);

   // Address decode and read data, captured in the setup cycle so the
   // answer is ready in the first access cycle without wait states.
   always_comb begin
      hit = 1'b1;
      rd_word = WORD_ZERO;
      case (paddr)
         OFS_INSTR: rd_word[OPC_W-1:0] = opcode;
         OFS_ACC: rd_word[NIB_W-1:0] = accumulator;
         OFS_PTR: rd_word[2*NIB_W-1:0] = {ptr_high, ptr_low};
         OFS_FLAGS: begin
            rd_word[FLG_CARRY] = carry_flag;
            rd_word[FLG_BUSY] = exec_pend;
         end
         OFS_TARGETS: begin
            rd_word[NIB_W-1:0] = display_ctrl_two;
            rd_word[TGT_TICK_LSB +: NIB_W] = display_tick_timer;
            rd_word[TGT_RELOAD_LSB +: NIB_W] = display_tick_reload;
            rd_word[TGT_CLK_LSB +: NIB_W] = clock_control_register;
            rd_word[TGT_TMR_BIT] = timer_ctrl_bit_register[0];
         end
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= WORD_ZERO;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (setup_cyc) begin
            prdata <= rd_word;
            pslverr <= !hit;
         end
      end
   end

   // An instruction word written by software executes in the next cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opcode <= OPC_RESET;
         exec_pend <= 1'b0;
      end else begin
         exec_pend <= wr_take && (paddr == OFS_INSTR);
         if (wr_take && (paddr == OFS_INSTR)) begin
            opcode <= pwdata[OPC_W-1:0];
         end
      end
   end

   // Accumulator and carry are written by software only; no transfer
   // instruction touches them.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accumulator <= NIB_RESET;
         carry_flag <= 1'b0;
      end else if (wr_take) begin
         if (paddr == OFS_ACC) begin
            accumulator <= pwdata[NIB_W-1:0];
         end
         if (paddr == OFS_FLAGS) begin
            carry_flag <= pwdata[FLG_CARRY];
         end
      end
   end

   // The store instruction wins over a software write of the pointer in
   // the same cycle, so the XOR result is never lost.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_high <= NIB_RESET;
         ptr_low <= NIB_RESET;
      end else if (is_store) begin
         ptr_high <= ptr_high ^ opcode[NIB_W-1:0];
      end else if (wr_take && (paddr == OFS_PTR)) begin
         ptr_low <= pwdata[NIB_W-1:0];
         ptr_high <= pwdata[PTR_HIGH_LSB +: NIB_W];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_we <= 1'b0;
         mem_addr <= {NIB_RESET, NIB_RESET};
         mem_wdata <= NIB_RESET;
      end else begin
         mem_we <= is_store;
         if (is_store) begin
            mem_addr <= {ptr_high, ptr_low};
            mem_wdata <= accumulator;
         end
      end
   end

   // Each strobe rises in the cycle in which its target already holds
   // the new value; the clock strobe depends on its own opcode only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         display_ctrl_two_we <= 1'b0;
         display_tick_we <= 1'b0;
         clock_control_we <= 1'b0;
         timer_ctrl_we <= 1'b0;
      end else begin
         display_ctrl_two_we <= is_dct2;
         display_tick_we <= is_tick;
         clock_control_we <= is_clk;
         timer_ctrl_we <= is_tmr;
      end
   end

   atx_target_reg #(.WIDTH(NIB_W)) u_dct2 (
      .pclk(pclk),
      .presetn(presetn),
      .load(is_dct2),
      .d(accumulator),
      .q(display_ctrl_two)
   );

   // Count and reload are loaded by the same term.
   atx_target_reg #(.WIDTH(NIB_W)) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .load(is_tick),
      .d(accumulator),
      .q(display_tick_timer)
   );

   atx_target_reg #(.WIDTH(NIB_W)) u_reload (
      .pclk(pclk),
      .presetn(presetn),
      .load(is_tick),
      .d(accumulator),
      .q(display_tick_reload)
   );

   atx_target_reg #(.WIDTH(NIB_W)) u_clk (
      .pclk(pclk),
      .presetn(presetn),
      .load(is_clk),
      .d(accumulator),
      .q(clock_control_register)
   );

   // Only bit zero of the accumulator reaches the timer bit.
   atx_target_reg #(.WIDTH(1)) u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .load(is_tmr),
      .d(accumulator[0:0]),
      .q(timer_ctrl_bit_register)
   );

   a_dct2_load: assert property (@(posedge pclk)
      disable iff (!presetn)
      is_dct2 |=> display_ctrl_two_we &&
         display_ctrl_two == $past(accumulator))
      else $error("display control two not loaded from accumulator");

   a_tick_pair: assert property (@(posedge pclk)
      disable iff (!presetn)
      is_tick |=> display_tick_we &&
         display_tick_timer == $past(accumulator) &&
         display_tick_reload == $past(accumulator))
      else $error("tick timer and reload not loaded together");

   a_store_addr: assert property (@(posedge pclk)
      disable iff (!presetn)
      is_store |=> mem_we && mem_addr == $past({ptr_high, ptr_low}) &&
         mem_wdata == $past(accumulator))
      else $error("memory store address or data wrong");

   a_xor_high: assert property (@(posedge pclk) disable iff (!presetn)
      is_store |=> ptr_high == ($past(ptr_high) ^ $past(opcode[3:0])))
      else $error("pointer high field not xored with immediate");

   a_clk_load: assert property (@(posedge pclk) disable iff (!presetn)
      is_clk |=> clock_control_register == $past(accumulator) &&
         $stable(display_ctrl_two) && $stable(display_tick_timer) &&
         $stable(timer_ctrl_bit_register) && $stable(ptr_high))
      else $error("clock mode load changed other state");

   a_tmr_bit: assert property (@(posedge pclk) disable iff (!presetn)
      is_tmr |=> timer_ctrl_we &&
         timer_ctrl_bit_register[0] == $past(accumulator[0]))
      else $error("timer bit not loaded from accumulator bit zero");

   a_clk_only: assert property (@(posedge pclk) disable iff (!presetn)
      clock_control_we |-> !display_ctrl_two_we && !display_tick_we &&
         !timer_ctrl_we && !mem_we)
      else $error("clock mode load strobed another target");

   a_carry_keep: assert property (@(posedge pclk)
      disable iff (!presetn)
      exec_pend |=> $stable(carry_flag) && $stable(accumulator))
      else $error("transfer altered carry or accumulator");

endmodule : atx_decoder

/* pkg/atx_pkg.sv */
package atx_pkg;

   // Register byte offsets on the APB side.
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_ACC = 8'h04;
   localparam logic [7:0] OFS_PTR = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0C;
   localparam logic [7:0] OFS_TARGETS = 8'h10;

   // Instruction words, 10 bits wide.
   localparam int unsigned OPC_W = 10;
   localparam logic [9:0] OPC_DCT2 = 10'h20B;
   localparam logic [9:0] OPC_TICK = 10'h20D;
   localparam logic [9:0] OPC_CLK = 10'h216;
   localparam logic [9:0] OPC_TMR = 10'h2AA;
   localparam logic [9:0] OPC_STORE = 10'h2B0;
   localparam logic [9:0] OPC_STORE_MASK = 10'h3F0;

   // Field positions.
   localparam int unsigned NIB_W = 4;
   localparam int unsigned PTR_HIGH_LSB = 4;
   localparam int unsigned FLG_CARRY = 0;
   localparam int unsigned FLG_BUSY = 1;
   localparam int unsigned TGT_TICK_LSB = 4;
   localparam int unsigned TGT_RELOAD_LSB = 8;
   localparam int unsigned TGT_CLK_LSB = 12;
   localparam int unsigned TGT_TMR_BIT = 16;

   // Reset values.
   localparam logic [3:0] NIB_RESET = 4'h0;
   localparam logic [9:0] OPC_RESET = 10'h000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage : atx_pkg

/* logic/atx_target_reg.sv */
`timescale 1ns/1ps
// Target register loaded by one decoded transfer instruction.
module atx_target_reg #(
   parameter int unsigned WIDTH = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Load
   input wire logic load,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else if (load) begin
         q <= d;
      end
   end

endmodule : atx_target_reg

/* testbench/accumulator_transfer_instructions_tb_top.sv */
`timescale 1ns/1ps
module accumulator_transfer_instructions_tb_top
   import atx_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
   logic [7:0] paddr, mem_addr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] dct2, tick, rel, clk_q, mem_wdata;
   logic [0:0] tmr;
   logic dct2_we, tick_we, clk_we, tmr_we, mem_we;
   logic [4:0] we_all;
   int store_q[$];
   int err_count, samples_checked, cycles, seed;
   int acc, ptr, cy, m_dct2, m_tick, m_rel, m_clk, m_tmr;

   atx_decoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .display_ctrl_two(dct2), .display_ctrl_two_we(dct2_we),
      .display_tick_timer(tick), .display_tick_reload(rel),
      .display_tick_we(tick_we), .clock_control_register(clk_q),
      .clock_control_we(clk_we), .timer_ctrl_bit_register(tmr),
      .timer_ctrl_we(tmr_we), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata));

   assign we_all = {dct2_we, tick_we, clk_we, tmr_we, mem_we};

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   // The request stays put until pready is seen high at a rising edge, for at most 16 edges.
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         check("pready wait", 32'h0000_0000, 32'h0000_0001);
      end
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic run(logic [9:0] op);
      logic [4:0] ew;
      int p0;
      int exp_w;
      int t_exp;
      acc = $random(seed) & 15;
      ptr = $random(seed) & 255;
      cy = $random(seed) & 1;
      p0 = ptr;
      ew = 5'h00;
      apb(1'b1, OFS_ACC, acc);
      apb(1'b1, OFS_PTR, ptr);
      apb(1'b1, OFS_FLAGS, cy);
      apb(1'b1, OFS_INSTR, {22'h000000, op});
      if (op == OPC_DCT2) begin
         m_dct2 = acc;
         ew = 5'h10;
      end else if (op == OPC_TICK) begin
         m_tick = acc;
         m_rel = acc;
         ew = 5'h08;
      end else if (op == OPC_CLK) begin
         m_clk = acc;
         ew = 5'h04;
      end else if (op == OPC_TMR) begin
         m_tmr = acc & 1;
         ew = 5'h02;
      end else if ((op & OPC_STORE_MASK) == OPC_STORE) begin
         ptr = ptr ^ ((op & 15) << 4);
         store_q.push_back(p0 << 4 | acc);
         ew = 5'h01;
      end
      @(posedge pclk);
      #1;
      check("strobes", we_all, ew);
      check("dct2 out", dct2, m_dct2);
      check("tick out", {tick, rel}, {m_tick[3:0], m_rel[3:0]});
      check("clock out", clk_q, m_clk);
      check("timer bit out", tmr, m_tmr);
      if (ew == 5'h01) begin
         exp_w = store_q.pop_front();
         check("store addr", mem_addr, exp_w >> 4);
         check("store data", mem_wdata, exp_w & 15);
      end
      @(posedge pclk);
      #1;
      check("strobes after", we_all, 0);
      t_exp = m_dct2 | m_tick << 4 | m_rel << 8 | m_clk << 12 | m_tmr << 16;
      apb(1'b0, OFS_TARGETS, 0);
      check("targets", rd, t_exp);
      check("targets err", rd_err, 0);
      apb(1'b0, OFS_ACC, 0);
      check("acc", rd, acc);
      apb(1'b0, OFS_PTR, 0);
      check("ptr", rd, ptr);
      apb(1'b0, OFS_FLAGS, 0);
      check("carry", rd & 1, cy);
      $display("test opcode %h done", op);
   endtask : run

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // A hang is cut short well above the roughly 770 cycles the run needs.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         final_report();
      end
   end

   initial begin
      seed = 32'hab3d3365;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      {m_dct2, m_tick, m_rel, m_clk, m_tmr} = '0;
      repeat (6) @(posedge pclk);
      check("pready in reset", pready, 0);
      presetn <= 1'b1;
      apb(1'b0, OFS_TARGETS, 0);
      check("targets reset", rd, 0);
      apb(1'b0, 8'h14, 0);
      check("unmapped err", rd_err, 1);
      check("unmapped data", rd, 0);
      $display("test register access done");
      for (int k = 0; k < 3; k++) begin
         run(OPC_DCT2);
         run(OPC_TICK);
         run(OPC_CLK);
         run(OPC_TMR);
      end
      for (int j = 0; j < 16; j++) begin
         run(OPC_STORE | j[9:0]);
      end
      run(10'h20C);
      final_report();
   end
endmodule : accumulator_transfer_instructions_tb_top
